// File: hdl/jbc_jitter_corr.sv
// What this block does
// - A 2048 x 8 symbol RAM buffers demodulated symbols and absorbs up to three frames of jitter either way.
// - The write position is watched all the time and steered to the buffer centre through the servo divisor.
// - The divisor is 588 when centred, 589 when one to three frames behind and 587 when one to three ahead.
// - At four or more frames off centre either way the write address is forced back to centre at once.
// - After such a recentre the audio output is muted for 128 frame periods.
// - On crystal frame timing, C1 checks, corrects and stores its flags, then C2 checks, corrects, flags and writes back.
// - C1 clears flags for zero or one error, corrects two but sets flags, and leaves three or more uncorrected with flags set.
// - C2 clears flags for no error and corrects one error with flags cleared.
// - Two C2 errors both on C1 flags are corrected and cleared, unless seven or more C1 flags, then C1 flags are copied.
// - Two C2 errors with one on a C1 flag are left; flags set if five or fewer C1 flags, else C1 flags copied.
// - Two C2 errors on no C1 flag are left; flags set if two or fewer C1 flags, else C1 flags copied.
// - Three or more C2 errors are left; flags set if two or fewer C1 flags, else C1 flags copied unchanged.
`timescale 1ns/1ns
`default_nettype none
`include "jbc_defines.svh"

module jbc_fifo
#(
    parameter int W     = 9,
    parameter int DEPTH = 16
)
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem [0:DEPTH-1];
    logic [PW-1:0] wp_reg;
    logic [PW-1:0] rp_reg;
    logic [PW:0]   cnt_reg;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_reg != (PW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem[rp_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_reg] <= in_data;
    end

    // Depth must be a power of two so the pointers wrap on their own
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wp_reg  <= push ? wp_reg + 1'b1 : wp_reg;
            rp_reg  <= pop ? rp_reg + 1'b1 : rp_reg;
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module jbc_jitter_corr
#(
    parameter int DW         = 8,
    parameter int AW         = 11,
    parameter int FIFO_DEPTH = 16
)
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire logic [DW-1:0]     in_sym,
    input  wire logic              in_sof,
    input  wire logic              frame_tick,
    output logic [9:0]             servo_div,
    output logic                   mute,
    output logic                   cw_valid,
    output logic [DW-1:0]          cw_sym,
    output logic                   cw_last,
    output logic                   cw_c2,
    input  wire logic              res_valid,
    input  wire jbc_pkg::jbc_errs_e res_cnt,
    input  wire logic [4:0]        res_pos0,
    input  wire logic [4:0]        res_pos1,
    input  wire logic [DW-1:0]     res_val0,
    input  wire logic [DW-1:0]     res_val1,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [DW-1:0]          out_sym,
    output logic                   out_flag
);
    import jbc_pkg::*;

    localparam int FW = AW - 5;

    function automatic logic [4:0] popcnt(input logic [27:0] v);
        logic [4:0] n;
        n = 5'd0;
        for (int i = 0; i < `JBC_C2_SYMS; i++)
            n = n + 5'(v[i]);
        return n;
    endfunction

    // Symbol RAM, 32 symbols to a frame slot
    logic [DW-1:0]        mem [0:(1<<AW)-1];
    logic [DW-1:0]        ram_q_reg;
    logic [AW-1:0]        rd_addr;
    logic [AW-1:0]        wr_addr;

    logic                 f_valid;
    logic                 f_ready;
    logic [DW:0]          f_data;
    logic                 pop;
    logic                 sof_mid;
    logic [FW-1:0]        wr_fr_use;
    logic [4:0]           wr_idx_use;
    logic [FW-1:0]        wr_fr_reg;
    logic [4:0]           wr_idx_reg;

    logic signed [FW-1:0] pos;
    logic signed [FW-1:0] lim;
    logic                 force_hit;
    logic [9:0]           div_next;
    logic [9:0]           div_reg;
    logic [7:0]           mute_cnt_reg;

    jbc_state_e           st_reg;
    logic [4:0]           idx_reg;
    logic [FW-1:0]        rd_fr_reg;
    logic [31:0]          c1f_reg;
    logic [27:0]          c2f_reg;
    logic [4:0]           pos0_reg;
    logic [4:0]           pos1_reg;
    logic [DW-1:0]        val0_reg;
    logic [DW-1:0]        val1_reg;
    logic [1:0]           ncorr_reg;
    logic                 fix_n_reg;
    logic                 fix_c2_reg;
    logic                 cw_valid_reg;
    logic                 cw_last_reg;
    logic                 cw_c2_reg;

    logic [4:0]           fix_pos;
    logic [DW-1:0]        fix_val;
    logic                 fix_we;
    logic                 fix_done;
    logic                 in_rd;
    logic [4:0]           rd_last;

    logic [4:0]           c1_n;
    logic                 m0;
    logic                 m1;
    jbc_flag_act_e        c2_act;
    logic [1:0]           c2_ncorr;
    logic [27:0]          c2f_next;

    // Input absorbs demodulator bursts while a correction write holds the RAM
    jbc_fifo #(.W(DW+1), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   ({in_sof, in_sym}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // Write side: a frame start mid-slot begins the next slot
    assign f_ready    = !fix_we;
    assign pop        = f_valid && f_ready;
    assign sof_mid    = f_data[DW] && wr_idx_reg != 5'd0;
    assign wr_fr_use  = sof_mid ? wr_fr_reg + 1'b1 : wr_fr_reg;
    assign wr_idx_use = sof_mid ? 5'd0 : wr_idx_reg;
    assign wr_addr    = {wr_fr_use, wr_idx_use};

    // Position of the write slot against the centre ahead of the reader
    assign pos       = $signed(wr_fr_reg - rd_fr_reg
                               - FW'(`JBC_CENTRE_OFS));
    assign lim       = $signed(FW'(`JBC_FORCE_LIMIT));
    assign force_hit = pos >= lim || pos <= -lim;
    assign div_next  = pos > 0 ? `JBC_DIV_AHEAD
                     : pos < 0 ? `JBC_DIV_BEHIND
                     : `JBC_DIV_CENTRE;
    assign servo_div = div_reg;
    assign mute      = mute_cnt_reg != 8'd0;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_fr_reg  <= FW'(`JBC_CENTRE_OFS);
            wr_idx_reg <= 5'd0;
        end
        else if (force_hit)
        begin
            wr_fr_reg  <= rd_fr_reg + FW'(`JBC_CENTRE_OFS);
            wr_idx_reg <= 5'd0;
        end
        else if (pop)
        begin
            wr_idx_reg <= wr_idx_use + 5'd1;
            wr_fr_reg  <= wr_idx_use == `JBC_C1_LAST ? wr_fr_use + 1'b1
                                                     : wr_fr_use;
        end
    end

    // Recentre errors escape the flags, so the output is held quiet
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_reg      <= `JBC_DIV_CENTRE;
            mute_cnt_reg <= 8'd0;
        end
        else
        begin
            div_reg <= div_next;
            if (force_hit)
                mute_cnt_reg <= `JBC_MUTE_FRAMES;
            else if (frame_tick && mute)
                mute_cnt_reg <= mute_cnt_reg - 8'd1;
        end
    end

    // RAM ports: correction writes take priority over incoming symbols
    assign fix_pos = fix_n_reg ? pos1_reg : pos0_reg;
    assign fix_val = fix_n_reg ? val1_reg : val0_reg;
    assign fix_we  = st_reg == ST_FIX_WR;
    assign rd_addr = (st_reg == ST_FIX_RD || fix_we)
                   ? {rd_fr_reg, fix_pos} : {rd_fr_reg, idx_reg};

    always_ff @(posedge clk)
    begin
        if (fix_we)
            mem[rd_addr] <= ram_q_reg ^ fix_val;
        else if (pop)
            mem[wr_addr] <= f_data[DW-1:0];
        ram_q_reg <= mem[rd_addr];
    end

    // C2 flag handling from the C1 flags inside the C2 codeword
    assign c1_n = popcnt(c1f_reg[27:0]);
    assign m0   = c1f_reg[res_pos0];
    assign m1   = c1f_reg[res_pos1];

    always_comb
    begin
        c2_act   = FL_COPY;
        c2_ncorr = 2'd0;
        case (res_cnt)
            ERR_NONE:
            begin
                c2_act = FL_CLEAR;
            end
            ERR_ONE:
            begin
                c2_act   = FL_CLEAR;
                c2_ncorr = 2'd1;
            end
            ERR_TWO:
            begin
                if (m0 && m1)
                begin
                    if (c1_n <= `JBC_C2_BOTH_MAX)
                    begin
                        c2_act   = FL_CLEAR;
                        c2_ncorr = 2'd2;
                    end
                end
                else if (m0 || m1)
                begin
                    if (c1_n <= `JBC_C2_ONE_MAX)
                        c2_act = FL_SET;
                end
                else if (c1_n <= `JBC_C2_NONE_MAX)
                    c2_act = FL_SET;
            end
            default:
            begin
                if (c1_n <= `JBC_C2_NONE_MAX)
                    c2_act = FL_SET;
            end
        endcase
    end

    assign c2f_next = c2_act == FL_CLEAR ? 28'h0000000
                    : c2_act == FL_SET   ? 28'hfffffff
                    : c1f_reg[27:0];

    assign in_rd    = st_reg == ST_C1_RD || st_reg == ST_C2_RD;
    assign rd_last  = st_reg == ST_C1_RD ? `JBC_C1_LAST : `JBC_C2_LAST;
    assign fix_done = fix_n_reg == 1'b1 || ncorr_reg == 2'd1;

    assign cw_valid  = cw_valid_reg;
    assign cw_last   = cw_last_reg;
    assign cw_c2     = cw_c2_reg;
    assign cw_sym    = ram_q_reg;
    assign out_valid = st_reg == ST_OUT_VL;
    assign out_sym   = ram_q_reg;
    assign out_flag  = c2f_reg[idx_reg];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cw_valid_reg <= 1'b0;
            cw_last_reg  <= 1'b0;
            cw_c2_reg    <= 1'b0;
        end
        else
        begin
            cw_valid_reg <= in_rd;
            cw_last_reg  <= in_rd && idx_reg == rd_last;
            cw_c2_reg    <= st_reg == ST_C2_RD;
        end
    end

    // Frame ticks that land while a frame is still in work are dropped
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg     <= ST_IDLE;
            idx_reg    <= 5'd0;
            rd_fr_reg  <= '0;
            c1f_reg    <= 32'h00000000;
            c2f_reg    <= 28'h0000000;
            pos0_reg   <= 5'd0;
            pos1_reg   <= 5'd0;
            val0_reg   <= '0;
            val1_reg   <= '0;
            ncorr_reg  <= 2'd0;
            fix_n_reg  <= 1'b0;
            fix_c2_reg <= 1'b0;
        end
        else
        begin
            case (st_reg)
                ST_IDLE:
                begin
                    idx_reg <= 5'd0;
                    if (frame_tick)
                        st_reg <= ST_C1_RD;
                end
                ST_C1_RD, ST_C2_RD:
                begin
                    idx_reg <= idx_reg + 5'd1;
                    if (idx_reg == rd_last)
                        st_reg <= st_reg == ST_C1_RD ? ST_C1_WT : ST_C2_WT;
                end
                ST_C1_WT:
                begin
                    if (res_valid)
                    begin
                        pos0_reg   <= res_pos0;
                        pos1_reg   <= res_pos1;
                        val0_reg   <= res_val0;
                        val1_reg   <= res_val1;
                        fix_n_reg  <= 1'b0;
                        fix_c2_reg <= 1'b0;
                        idx_reg    <= 5'd0;
                        c1f_reg    <= res_cnt == ERR_TWO || res_cnt == ERR_MANY
                                    ? 32'hffffffff : 32'h00000000;
                        ncorr_reg  <= res_cnt == ERR_MANY ? 2'd0
                                    : 2'(res_cnt);
                        st_reg     <= res_cnt == ERR_NONE || res_cnt == ERR_MANY
                                    ? ST_C2_RD : ST_FIX_RD;
                    end
                end
                ST_C2_WT:
                begin
                    if (res_valid)
                    begin
                        pos0_reg   <= res_pos0;
                        pos1_reg   <= res_pos1;
                        val0_reg   <= res_val0;
                        val1_reg   <= res_val1;
                        fix_n_reg  <= 1'b0;
                        fix_c2_reg <= 1'b1;
                        idx_reg    <= 5'd0;
                        c2f_reg    <= c2f_next;
                        ncorr_reg  <= c2_ncorr;
                        st_reg     <= c2_ncorr == 2'd0 ? ST_OUT_RD : ST_FIX_RD;
                    end
                end
                ST_FIX_RD:
                begin
                    st_reg <= ST_FIX_WR;
                end
                ST_FIX_WR:
                begin
                    fix_n_reg <= 1'b1;
                    if (fix_done)
                        st_reg <= fix_c2_reg ? ST_OUT_RD : ST_C2_RD;
                    else
                        st_reg <= ST_FIX_RD;
                end
                ST_OUT_RD:
                begin
                    st_reg <= ST_OUT_VL;
                end
                ST_OUT_VL:
                begin
                    if (out_ready)
                    begin
                        idx_reg <= idx_reg + 5'd1;
                        if (idx_reg == `JBC_C2_LAST)
                        begin
                            rd_fr_reg <= rd_fr_reg + 1'b1;
                            st_reg    <= ST_IDLE;
                        end
                        else
                            st_reg <= ST_OUT_RD;
                    end
                end
                default:
                begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// File: hdl/jbc_defines.svh
`ifndef JBC_DEFINES_SVH
`define JBC_DEFINES_SVH

// Servo divisors on the recovered clock side
`define JBC_DIV_CENTRE   10'd588
`define JBC_DIV_BEHIND   10'd589
`define JBC_DIV_AHEAD    10'd587

// Buffer position handling, in frames
`define JBC_CENTRE_OFS   8
`define JBC_FORCE_LIMIT  4
`define JBC_MUTE_FRAMES  8'd128

// Codeword lengths as last symbol index, with the C2 length also as a symbol count
`define JBC_C1_LAST      5'd31
`define JBC_C2_LAST      5'd27
`define JBC_C2_SYMS      28

// C2 flag thresholds on the C1 flag count
`define JBC_C2_BOTH_MAX  5'd6
`define JBC_C2_ONE_MAX   5'd5
`define JBC_C2_NONE_MAX  5'd2

`endif

// File: hdl/jbc_pkg.sv
package jbc_pkg;

    typedef enum logic [3:0]
    {
        ST_IDLE   = 4'h0,
        ST_C1_RD  = 4'h1,
        ST_C1_WT  = 4'h2,
        ST_FIX_RD = 4'h3,
        ST_FIX_WR = 4'h4,
        ST_C2_RD  = 4'h5,
        ST_C2_WT  = 4'h6,
        ST_OUT_RD = 4'h7,
        ST_OUT_VL = 4'h8
    } jbc_state_e;

    typedef enum logic [1:0]
    {
        ERR_NONE = 2'h0,
        ERR_ONE  = 2'h1,
        ERR_TWO  = 2'h2,
        ERR_MANY = 2'h3
    } jbc_errs_e;

    typedef enum logic [1:0]
    {
        FL_CLEAR = 2'h0,
        FL_SET   = 2'h1,
        FL_COPY  = 2'h2
    } jbc_flag_act_e;

endpackage

// File: tb/jbc_syndrome_model.sv
`timescale 1ns/1ns
`default_nettype none
module jbc_syndrome_model
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          cw_valid,
    input  wire logic          cw_last,
    input  wire logic          cw_c2,
    output logic               res_valid,
    output jbc_pkg::jbc_errs_e res_cnt,
    output logic [4:0]         res_pos0,
    output logic [4:0]         res_pos1,
    output logic [7:0]         res_val0,
    output logic [7:0]         res_val1
);
    import jbc_pkg::*;
    logic       busy_reg;
    logic       c2_reg;
    logic [5:0] wait_reg;
    logic [4:0] span;
    // Two disjoint halves keep the two error positions distinct
    assign span = c2_reg ? 5'd13 : 5'd15;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_reg  <= 1'b0;
            c2_reg    <= 1'b0;
            wait_reg  <= '0;
            res_valid <= 1'b0;
            res_cnt   <= ERR_NONE;
            res_pos0  <= '0;
            res_pos1  <= '0;
            res_val0  <= '0;
            res_val1  <= '0;
        end
        else
        begin
            // Fields are not held outside the result pulse
            res_valid <= 1'b0;
            res_cnt   <= jbc_errs_e'(~res_cnt);
            res_pos0  <= ~res_pos0;
            res_pos1  <= ~res_pos1;
            res_val0  <= ~res_val0;
            res_val1  <= ~res_val1;
            if (cw_valid && cw_last)
            begin
                busy_reg <= 1'b1;
                c2_reg   <= cw_c2;
                wait_reg <= 6'($urandom_range(2, 40));
            end
            else if (busy_reg && wait_reg != 6'h0)
                wait_reg <= wait_reg - 6'h1;
            else if (busy_reg)
            begin
                busy_reg  <= 1'b0;
                res_valid <= 1'b1;
                res_cnt   <= jbc_errs_e'($urandom_range(0, 3));
                res_pos0  <= 5'($urandom_range(0, span));
                res_pos1  <= span + 5'h1 + 5'($urandom_range(0, span));
                res_val0  <= 8'($urandom_range(1, 255));
                res_val1  <= 8'($urandom_range(1, 255));
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/jbc_jitter_corr_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "jbc_defines.svh"
module jbc_jitter_corr_chk
#(
    parameter int DW = 8
)
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          frame_tick,
    input  wire logic [9:0]    servo_div,
    input  wire logic          mute,
    input  wire logic          cw_valid,
    input  wire logic          cw_last,
    input  wire logic          cw_c2,
    input  wire logic          out_valid,
    input  wire logic          out_ready,
    input  wire logic [DW-1:0] out_sym,
    input  wire logic          out_flag
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_DIV_SET: assert property (servo_div inside {`JBC_DIV_CENTRE,
        `JBC_DIV_BEHIND, `JBC_DIV_AHEAD}) else $error("divisor off set");
    AST_DIV_RST: assert property ($rose(arst_n) |->
        servo_div == `JBC_DIV_CENTRE && !mute) else $error("bad start");
    AST_DIV_STEP: assert property (servo_div == `JBC_DIV_BEHIND |=>
        servo_div != `JBC_DIV_AHEAD) else $error("divisor jumped");
    AST_FORCE_DIV: assert property ($rose(mute) |=>
        servo_div == `JBC_DIV_CENTRE) else $error("not recentred");
    AST_MUTE_HOLD: assert property (mute && !frame_tick |=> mute)
        else $error("mute dropped without tick");
    AST_MUTE_LEN: assert property ($rose(mute) |-> mute[*8])
        else $error("mute too short");
    AST_C1_RUN: assert property ($rose(cw_valid) && !cw_c2 |->
        (cw_valid && !cw_c2 && !cw_last)[*8] ##24 (cw_valid && cw_last))
        else $error("bad first stage stream");
    AST_C2_RUN: assert property ($rose(cw_valid) && cw_c2 |->
        (cw_valid && cw_c2 && !cw_last)[*8] ##20 (cw_valid && cw_last))
        else $error("bad second stage stream");
    AST_OUT_HOLD: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_sym) && $stable(out_flag))
        else $error("output not held");
    AST_OUT_GAP: assert property (out_valid && out_ready |=> !out_valid)
        else $error("no gap after output");
    AST_NO_MIX: assert property (cw_valid |-> !out_valid)
        else $error("output during check");
    cover property ($rose(mute));
    cover property (servo_div == `JBC_DIV_BEHIND);
    cover property (servo_div == `JBC_DIV_AHEAD);
    cover property (out_valid && out_ready && out_flag);
endmodule
bind jbc_jitter_corr jbc_jitter_corr_chk #(.DW(DW)) u_chk
(
    .clk(clk), .arst_n(arst_n), .frame_tick(frame_tick),
    .servo_div(servo_div), .mute(mute), .cw_valid(cw_valid),
    .cw_last(cw_last), .cw_c2(cw_c2), .out_valid(out_valid),
    .out_ready(out_ready), .out_sym(out_sym), .out_flag(out_flag)
);
`default_nettype wire

// File: tb/jbc_jitter_corr_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "jbc_defines.svh"
module jbc_jitter_corr_bench;
    import jbc_pkg::*;
    logic            clk = 0, arst_n = 0, in_valid = 0, in_sof = 0;
    logic            frame_tick = 0, out_ready = 0, c1f = 0, lastc2 = 0;
    logic            eflag = 0;
    logic [7:0]      in_sym = '0;
    logic [7:0]      mem [2048];
    bit              kn [2048];
    wire logic       in_ready, mute, cw_valid, cw_last, cw_c2, res_valid;
    wire logic       out_valid, out_flag;
    wire logic [9:0] servo_div;
    wire logic [7:0] cw_sym, res_val0, res_val1, out_sym;
    wire logic [4:0] res_pos0, res_pos1;
    wire jbc_errs_e  res_cnt;
    int              errors = 0, compares = 0, cyc = 0, n;
    int              wr = 8, rd = 0, idx = 0, mutec = 0, ci = 0;

    jbc_jitter_corr DUT
    (
        .clk(clk), .arst_n(arst_n), .in_valid(in_valid), .in_ready(in_ready),
        .in_sym(in_sym), .in_sof(in_sof), .frame_tick(frame_tick),
        .servo_div(servo_div), .mute(mute), .cw_valid(cw_valid),
        .cw_sym(cw_sym), .cw_last(cw_last), .cw_c2(cw_c2),
        .res_valid(res_valid), .res_cnt(res_cnt), .res_pos0(res_pos0),
        .res_pos1(res_pos1), .res_val0(res_val0), .res_val1(res_val1),
        .out_valid(out_valid), .out_ready(out_ready), .out_sym(out_sym),
        .out_flag(out_flag)
    );
    jbc_syndrome_model u_syn
    (
        .clk(clk), .arst_n(arst_n), .cw_valid(cw_valid), .cw_last(cw_last),
        .cw_c2(cw_c2), .res_valid(res_valid), .res_cnt(res_cnt),
        .res_pos0(res_pos0), .res_pos1(res_pos1), .res_val0(res_val0),
        .res_val1(res_val1)
    );

    always #20 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Slot counters are modular in the design, so plain differences agree
    task automatic upd_pos;
        int p;
        p = wr - rd - 8;
        if (p >= `JBC_FORCE_LIMIT || p <= -`JBC_FORCE_LIMIT)
        begin
            wr = rd + 8;
            idx = 0;
            mutec = 128;
        end
    endtask

    task automatic chk_pos;
        int p;
        p = wr - rd - 8;
        chk(servo_div, p < 0 ? `JBC_DIV_BEHIND : (p > 0 ? `JBC_DIV_AHEAD
            : `JBC_DIV_CENTRE));
        chk(mute, mutec > 0);
    endtask

    task automatic put_frame;
        int a;
        for (int i = 0; i < 32; i++)
        begin
            do @(negedge clk); while (in_ready !== 1'b1);
            in_valid = 1'b1;
            in_sof = (i == 0);
            in_sym = 8'($urandom);
            a = wr % 64 * 32 + idx;
            mem[a] = in_sym;
            kn[a] = 1;
            idx++;
            if (idx == 32)
            begin
                idx = 0;
                wr++;
                upd_pos();
            end
        end
        @(negedge clk) in_valid = 1'b0;
        repeat (40) @(negedge clk);
        chk_pos();
    endtask

    task automatic correct;
        int a;
        @(negedge clk) frame_tick = 1'b1;
        if (mutec > 0)
            mutec--;
        @(negedge clk) frame_tick = 1'b0;
        for (int i = 0; i < 28; i++)
        begin
            while (out_valid !== 1'b1) @(negedge clk);
            repeat ($urandom_range(0, 2)) @(negedge clk);
            a = rd % 64 * 32 + i;
            if (kn[a])
                chk(out_sym, mem[a]);
            chk(out_flag, eflag);
            out_ready = 1'b1;
            @(negedge clk) out_ready = 1'b0;
        end
        rd++;
        upd_pos();
        repeat (3) @(negedge clk);
        chk_pos();
    endtask

    always @(negedge clk)
    begin
        if (cw_valid && kn[rd % 64 * 32 + ci])
            chk(cw_sym, mem[rd % 64 * 32 + ci]);
        if (cw_valid)
            ci = cw_last ? 0 : ci + 1;
        if (cw_valid && cw_last)
            lastc2 = cw_c2;
        if (res_valid && !lastc2)
        begin
            c1f = res_cnt >= ERR_TWO;
            if (res_cnt == ERR_ONE || res_cnt == ERR_TWO)
                mem[rd % 64 * 32 + res_pos0] ^= res_val0;
            if (res_cnt == ERR_TWO)
                mem[rd % 64 * 32 + res_pos1] ^= res_val1;
        end
        else if (res_valid)
        begin
            n = c1f ? 28 : 0;
            eflag = (n <= 2) ? 1'b1 : c1f;
            if (res_cnt == ERR_NONE || res_cnt == ERR_ONE)
                eflag = 1'b0;
            if (res_cnt == ERR_ONE)
                mem[rd % 64 * 32 + res_pos0] ^= res_val0;
            if (res_cnt == ERR_TWO && c1f)
                eflag = n <= 6 ? 1'b0 : c1f;
        end
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            errors++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(32'h9dd6));
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk(servo_div, `JBC_DIV_CENTRE);
        chk(mute, 1'b0);
        chk(in_ready, 1'b1);
        $display("test reset ended");
        repeat (4) put_frame();
        $display("test ahead and forced recentre ended");
        repeat (3) correct();
        $display("test behind ended");
        repeat (128)
        begin
            put_frame();
            correct();
        end
        $display("test streaming correction and mute expiry ended");
        correct();
        $display("test recentre from behind ended");
        summarize();
    end
endmodule
`default_nettype wire
